/* inc/scm_pkg.sv */
// Package: widths, field positions and codes of the sensor correction datapath
package scm_pkg;

  // ----------------------------------------
  // Reading widths and limits
  // ----------------------------------------
  localparam int RAW_W = 14;
  localparam logic [13:0] RAW_MAX = 14'h3fff;
  localparam int TEMP_STEP_BITS = 2;
  localparam int TEMP_REF_LSB = 7;
  localparam int TEMP_REF_W = 7;

  // ----------------------------------------
  // Coefficient field positions
  // ----------------------------------------
  localparam int GAIN_B_SCALE_BIT = 14;
  localparam int GAIN_B_FRAC = 11;
  localparam int GAIN_B_SCALE_SHIFT = 3;
  localparam int TC_NEG_OFFSET_BIT = 0;
  localparam int TC_SCALE_BIT = 1;
  localparam int TC_NEG_GAIN_BIT = 2;
  localparam int SOC_SIGN_BIT = 7;
  localparam int TCO_SCALE_SHIFT = 3;

  // ----------------------------------------
  // Second order target codes
  // ----------------------------------------
  localparam logic [1:0] SOT_TO_BRIDGE = 2'h0;
  localparam logic [1:0] SOT_TO_GAIN_TC = 2'h1;
  localparam logic [1:0] SOT_TO_OFFSET_TC = 2'h2;
  localparam logic [1:0] SOT_TO_NONE = 2'h3;

  // ----------------------------------------
  // Internal arithmetic scaling
  // ----------------------------------------
  localparam int ACC_W = 48;
  localparam int GAIN_ADJ_SHIFT = 4;
  localparam int GAIN_UNITY_SHIFT = 16;
  localparam int OFFSET_SOT_SHIFT = 4;
  localparam int OFFSET_ADJ_SHIFT = 2;
  localparam int BRIDGE_SQ_SHIFT = 14;
  localparam int BRIDGE_SOT_SHIFT = 9;
  localparam int BRIDGE_LIN_LIMIT = 17;
  localparam int GAIN_T_FRAC = 7;
  localparam int OFFSET_T_SHIFT = 6;

  typedef struct packed {
    logic [14:0] gain_b;
    logic [13:0] offset_b;
    logic [7:0] gain_t;
    logic [7:0] offset_t;
    logic [7:0] tcg;
    logic [7:0] tco;
    logic [2:0] tempco_config;
    logic [7:0] second_order_coef;
    logic [1:0] second_order_target;
    logic [6:0] cal_temp_reference;
  } scm_coef_t;

endpackage

/* rtl/scm_correction.sv */
// Sensor correction datapath: decodes calibration coefficients and corrects readings
// How it works
// RL1 - Bridge reading is unsigned 0..16383
// RL2 - Temperature reading unsigned, four counts per step
// RL3 - Span bit 14 multiplies span by eight
// RL4 - Span low bits: fixed point, top weighs four
// RL5 - Bridge zero is 14-bit unsigned integer
// RL6 - Temperature span: 8-bit, bit seven weighs one
// RL7 - Temperature zero is 8-bit two's complement
// RL8 - Offset tempco: sign bit0, x8 bit1
// RL9 - Gain tempco: magnitude plus sign, no scaling
// RL10 - Second-order term drives exactly one target; target code 11 drives none
// RL11 - Offset-tempco scaling also scales second-order term routed to offset
// RL12 - Correction arithmetic saturates, never wraps
// RL13 - Reference holds upper seven temperature bits
// RL14 - Host computes and writes all coefficients
// RL15 - Second-order coefficient is sign-magnitude, bit seven
// RL16 - Target 00 bridge, 01 gain, 10 offset
// RL17 - Tempco config bit two negates gain tempco
// RL18 - Negative zero converts to plain zero
`timescale 1ns/1ns
module scm_correction import scm_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Readings, same clock as the converter logic
  input wire logic in_valid,
  input wire logic [13:0] bridge_raw_reading,
  input wire logic [13:0] temp_raw_reading,
  // Coefficients as loaded from nonvolatile memory by the host
  input wire scm_coef_t coef,
  // Results
  output logic out_valid,
  output logic [13:0] bridge_corrected,
  output logic [13:0] temp_corrected,
  output logic target_prohibited
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic signed [8:0] sm_to_signed(input logic [7:0] mag, input logic neg);
    logic signed [8:0] v;
    v = $signed({1'b0, mag});
    sm_to_signed = neg ? -v : v; // RL18
  endfunction

  function automatic logic [13:0] sat_reading(input logic signed [ACC_W-1:0] v);
    if (v < 0) begin
      sat_reading = 14'h0000; // RL12
    end else if (v > $signed({{(ACC_W-RAW_W){1'b0}}, RAW_MAX})) begin
      sat_reading = RAW_MAX; // RL12
    end else begin
      sat_reading = v[13:0]; // RL1
    end
  endfunction

  // ----------------------------------------
  // Stage 1: coefficient decode
  // ----------------------------------------
  wire logic [13:0] temp_stepped = {temp_raw_reading[13:TEMP_STEP_BITS], 2'h0}; // RL2
  wire logic [6:0] temp_upper = temp_raw_reading[13:TEMP_REF_LSB]; // RL13
  wire logic signed [7:0] next_dt = $signed({1'b0, temp_upper}) -
                                    $signed({1'b0, coef.cal_temp_reference}); // RL13
  wire logic [16:0] gain_b_low = {3'h0, coef.gain_b[13:0]}; // RL4
  wire logic [16:0] next_gain_b = coef.gain_b[GAIN_B_SCALE_BIT] ?
                                  (gain_b_low << GAIN_B_SCALE_SHIFT) : gain_b_low; // RL3
  wire logic tco_scaled = coef.tempco_config[TC_SCALE_BIT];
  wire logic signed [8:0] tco_s = sm_to_signed(coef.tco,
                                               coef.tempco_config[TC_NEG_OFFSET_BIT]); // RL8
  wire logic signed [11:0] next_tco = tco_scaled ? (12'(tco_s) <<< TCO_SCALE_SHIFT)
                                                 : 12'(tco_s); // RL8
  wire logic signed [8:0] next_tcg = sm_to_signed(coef.tcg,
                                                  coef.tempco_config[TC_NEG_GAIN_BIT]); // RL9 RL17
  wire logic signed [8:0] sot_s = sm_to_signed({1'b0, coef.second_order_coef[6:0]},
                                               coef.second_order_coef[SOC_SIGN_BIT]); // RL15
  wire logic [1:0] tgt = coef.second_order_target;
  wire logic signed [8:0] next_sot_b = (tgt == SOT_TO_BRIDGE) ? sot_s : 9'sh000; // RL10 RL16
  wire logic signed [8:0] next_sot_g = (tgt == SOT_TO_GAIN_TC) ? sot_s : 9'sh000; // RL10 RL16
  wire logic signed [11:0] sot_o_base = (tgt == SOT_TO_OFFSET_TC) ? 12'(sot_s) : 12'sh000;
  wire logic signed [11:0] next_sot_o = tco_scaled ? (sot_o_base <<< TCO_SCALE_SHIFT)
                                                   : sot_o_base; // RL11

  logic s1_valid;
  logic signed [7:0] dt;
  logic [16:0] gain_b_eff;
  logic signed [11:0] tco_eff;
  logic signed [8:0] tcg_eff;
  logic signed [8:0] sot_b;
  logic signed [8:0] sot_g;
  logic signed [11:0] sot_o;
  logic [13:0] offset_b;
  logic [7:0] gain_t;
  logic signed [7:0] offset_t;
  logic [13:0] raw_b;
  logic [13:0] raw_t;
  logic s1_prohibited;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_valid <= 1'b0;
      dt <= 8'sh00;
      gain_b_eff <= 17'h00000;
      tco_eff <= 12'sh000;
      tcg_eff <= 9'sh000;
      sot_b <= 9'sh000;
      sot_g <= 9'sh000;
      sot_o <= 12'sh000;
      offset_b <= 14'h0000;
      gain_t <= 8'h00;
      offset_t <= 8'sh00;
      raw_b <= 14'h0000;
      raw_t <= 14'h0000;
      s1_prohibited <= 1'b0;
    end else begin
      s1_valid <= in_valid;
      if (in_valid) begin
        dt <= next_dt;
        gain_b_eff <= next_gain_b;
        tco_eff <= next_tco;
        tcg_eff <= next_tcg;
        sot_b <= next_sot_b;
        sot_g <= next_sot_g;
        sot_o <= next_sot_o;
        offset_b <= coef.offset_b; // RL5
        gain_t <= coef.gain_t; // RL6
        offset_t <= $signed(coef.offset_t); // RL7
        raw_b <= bridge_raw_reading; // RL1
        raw_t <= temp_stepped;
        s1_prohibited <= (tgt == SOT_TO_NONE); // RL16
      end
    end
  end

  // ----------------------------------------
  // Stage 2: correction arithmetic
  // ----------------------------------------
  // Wide signed accumulators so intermediate terms cannot wrap before clamping
  wire logic signed [ACC_W-1:0] dt_w = ACC_W'(dt);
  wire logic signed [ACC_W-1:0] dt2 = dt_w * dt_w;
  wire logic signed [ACC_W-1:0] gain_adj = ((ACC_W'(tcg_eff) * dt_w) <<< GAIN_ADJ_SHIFT) +
                                          ACC_W'(sot_g) * dt2;
  wire logic signed [ACC_W-1:0] gain_factor_raw = (ACC_W'(1) <<< GAIN_UNITY_SHIFT) + gain_adj;
  // Gain can not fold negative: a factor below zero is held at zero
  wire logic signed [ACC_W-1:0] gain_factor = (gain_factor_raw < 0) ? '0 : gain_factor_raw; // RL12
  wire logic signed [ACC_W-1:0] gain_eff = ($signed({31'h0, gain_b_eff}) * gain_factor)
                                           >>> GAIN_UNITY_SHIFT;
  wire logic signed [ACC_W-1:0] offset_adj = ((ACC_W'(tco_eff) * dt_w) +
                                             ((ACC_W'(sot_o) * dt2) >>> OFFSET_SOT_SHIFT))
                                             >>> OFFSET_ADJ_SHIFT;
  wire logic signed [ACC_W-1:0] offset_eff = $signed({34'h0, offset_b}) + offset_adj; // RL5
  wire logic signed [ACC_W-1:0] diff = $signed({34'h0, raw_b}) - offset_eff;
  wire logic signed [ACC_W-1:0] lin = (diff * gain_eff) >>> GAIN_B_FRAC; // RL4
  wire logic signed [ACC_W-1:0] lin_lim = ACC_W'(1) <<< BRIDGE_LIN_LIMIT;
  wire logic signed [ACC_W-1:0] lin_c = (lin > lin_lim) ? lin_lim :
                                        (lin < -lin_lim) ? -lin_lim : lin; // RL12
  wire logic signed [ACC_W-1:0] lin_sq = (lin_c * lin_c) >>> BRIDGE_SQ_SHIFT;
  wire logic signed [ACC_W-1:0] bridge_pre = lin_c +
                                             ((ACC_W'(sot_b) * lin_sq) >>> BRIDGE_SOT_SHIFT);
  wire logic signed [ACC_W-1:0] temp_pre =
    (($signed({40'h0, gain_t}) * $signed({34'h0, raw_t})) >>> GAIN_T_FRAC) +
    (ACC_W'(offset_t) <<< OFFSET_T_SHIFT); // RL6 RL7

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      bridge_corrected <= 14'h0000;
      temp_corrected <= 14'h0000;
      target_prohibited <= 1'b0;
    end else begin
      out_valid <= s1_valid;
      if (s1_valid) begin
        bridge_corrected <= sat_reading(bridge_pre); // RL12
        temp_corrected <= sat_reading(temp_pre); // RL12
        target_prohibited <= s1_prohibited;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_valid_latency: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL1
    in_valid |-> ##2 out_valid) else $error("result not two cycles after reading");
  chk_route_single: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL10
    s1_valid |-> ((sot_b != 0) + (sot_g != 0) + (sot_o != 0)) <= 1)
    else $error("second order term on two targets");
  chk_route_code: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL16
    in_valid && coef.second_order_target == SOT_TO_GAIN_TC |=> sot_b == 0 && sot_o == 0 &&
    sot_g == $past(sot_s)) else $error("gain target code misrouted");
  chk_tco_scale: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL8
    in_valid && coef.tempco_config[TC_SCALE_BIT] |=> tco_eff == 8 * $past(tco_s))
    else $error("offset tempco not scaled by eight");
  chk_sot_scale: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL11
    in_valid && tgt == SOT_TO_OFFSET_TC && coef.tempco_config[TC_SCALE_BIT]
    |=> sot_o == 8 * $past(sot_s)) else $error("second order term not scaled");
  chk_tcg_sign: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL17
    in_valid && coef.tempco_config[TC_NEG_GAIN_BIT] && coef.tcg != 0 |=> tcg_eff < 0)
    else $error("gain tempco sign ignored");
  chk_neg_zero: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL18
    in_valid && coef.second_order_coef[6:0] == 0 |=> sot_b == 0 && sot_g == 0 && sot_o == 0)
    else $error("negative zero not zero");
  chk_temp_ref: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL13
    in_valid |=> dt == $past(next_dt) && raw_t[1:0] == 2'h0)
    else $error("temperature delta wrong");
  chk_gain_scale: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL3
    in_valid && coef.gain_b[GAIN_B_SCALE_BIT] |=> gain_b_eff == 8 * $past(coef.gain_b[13:0]))
    else $error("span not scaled by eight");
  chk_bridge_sat: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL12
    s1_valid && bridge_pre < 0 |=> bridge_corrected == 14'h0000)
    else $error("bridge result wrapped");
  // Compare against a signed limit; an unsigned one would treat negative results as above it
  chk_bridge_high: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL12
    s1_valid && bridge_pre > $signed(ACC_W'(RAW_MAX)) |=> bridge_corrected == RAW_MAX)
    else $error("bridge result not clamped high");
  chk_temp_low: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL12
    s1_valid && temp_pre < 0 |=> temp_corrected == 14'h0000)
    else $error("temperature result wrapped low");
  chk_temp_high: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL12
    s1_valid && temp_pre > $signed(ACC_W'(RAW_MAX)) |=> temp_corrected == RAW_MAX)
    else $error("temperature result not clamped high");
  chk_target_flag: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL16
    s1_valid |=> target_prohibited == $past(s1_prohibited))
    else $error("prohibited target not flagged");

endmodule // scm_correction

/* tb/tb_top.sv */
// Self-checking testbench for the sensor correction datapath
`timescale 1ns/1ns
module tb_top import scm_pkg::*;;
  // ----------------------------------------
  // Clock, reset, ports, bookkeeping
  // ----------------------------------------
  typedef struct {scm_coef_t c; logic [13:0] rb, rt, eb, et; logic ep;} scm_row_t;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic in_valid = 1'b0;
  logic [13:0] bridge_raw_reading = 14'h0;
  logic [13:0] temp_raw_reading = 14'h0;
  scm_coef_t coef = '0;
  logic out_valid, target_prohibited;
  logic [13:0] bridge_corrected, temp_corrected;
  int error_cnt = 0;
  int samples_checked = 0;
  scm_row_t rows[$];
  scm_coef_t c;

  scm_correction i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .in_valid(in_valid),
    .bridge_raw_reading(bridge_raw_reading), .temp_raw_reading(temp_raw_reading),
    .coef(coef), .out_valid(out_valid), .bridge_corrected(bridge_corrected),
    .temp_corrected(temp_corrected), .target_prohibited(target_prohibited));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Reference arithmetic, 64-bit so nothing wraps
  // ----------------------------------------
  function automatic longint sm(input logic [7:0] m, input logic n);
    return n ? -longint'(m) : longint'(m);
  endfunction
  function automatic logic [13:0] sat(input longint v);
    return v < 0 ? 14'h0 : (v > 16383 ? 14'h3fff : v[13:0]);
  endfunction
  task automatic add(input scm_coef_t k, input logic [13:0] rb, input logic [13:0] rt);
    scm_row_t r;
    longint dt, g, tco, s, so, f, off, lin;
    logic [1:0] tg;
    tg = k.second_order_target;
    dt = longint'(rt[13:7]) - longint'(k.cal_temp_reference);
    g = longint'(k.gain_b[13:0]) * (k.gain_b[14] ? 8 : 1);
    tco = sm(k.tco, k.tempco_config[0]) * (k.tempco_config[1] ? 8 : 1);
    s = sm({1'b0, k.second_order_coef[6:0]}, k.second_order_coef[7]);
    so = (tg == 2'h2) ? s * (k.tempco_config[1] ? 8 : 1) : 0;
    f = 65536 + ((sm(k.tcg, k.tempco_config[2]) * dt) <<< 4);
    f = f + ((tg == 2'h1) ? s * dt * dt : 0);
    f = f < 0 ? 0 : f;
    off = longint'(k.offset_b) + ((tco * dt + ((so * dt * dt) >>> 4)) >>> 2);
    lin = ((longint'(rb) - off) * ((g * f) >>> 16)) >>> 11;
    lin = lin > 131072 ? 131072 : (lin < -131072 ? -131072 : lin);
    r.eb = sat(lin + ((((tg == 2'h0) ? s : 0) * ((lin * lin) >>> 14)) >>> 9));
    r.et = sat(((longint'(k.gain_t) * longint'({rt[13:2], 2'b00})) >>> 7)
      + longint'($signed(k.offset_t)) * 64);
    r.ep = (tg == 2'h3);
    r.c = k;
    r.rb = rb;
    r.rt = rt;
    rows.push_back(r);
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("summary: %0d checks, %0d mismatches", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog, far beyond the sixty or so cycles needed
  // ----------------------------------------
  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    c = '0;
    c.gain_b = 15'h0800;
    c.gain_t = 8'h80;
    add(c, 14'd1000, 14'd1003);
    c.gain_b = 15'h4800;
    add(c, 14'd2000, 14'd1000);
    c.gain_b = 15'h2531;
    c.offset_b = 14'h0ffc;
    c.gain_t = 8'hff;
    c.offset_t = 8'hd7;
    add(c, 14'd9000, 14'd8000);
    c.gain_b = 15'h7fff;
    add(c, 14'd16383, 14'd16383);
    c.gain_b = 15'h0800;
    c.offset_b = 14'h3fff;
    c.offset_t = 8'h80;
    add(c, 14'd0, 14'd100);
    c = '0;
    c.gain_b = 15'h0800;
    c.gain_t = 8'h80;
    c.tcg = 8'h40;
    c.tco = 8'h30;
    c.cal_temp_reference = 7'h20;
    for (int k = 0; k < 40; k++) begin
      c.tempco_config = k[2:0];
      c.second_order_target = k[4:3];
      c.second_order_coef = k[5] ? 8'h80 : 8'h85;
      c.second_order_coef = (k >= 32) ? {k[0], 7'h00} : c.second_order_coef;
      add(c, 14'd8000, 14'h2000);
    end
    c.second_order_target = 2'h0;
    c.second_order_coef = 8'hff;
    add(c, 14'd16000, 14'h2000);
    repeat (3) begin
      @(negedge sys_clk);
      chk("out_valid", out_valid, 16'h0);
      chk("bridge_corrected", bridge_corrected, 16'h0);
      chk("temp_corrected", temp_corrected, 16'h0);
      chk("target_prohibited", target_prohibited, 16'h0);
    end
    sys_rst = 1'b0;
    // Back to back stream; results surface two falling edges later
    for (int k = 0; k < rows.size() + 2; k++) begin
      @(negedge sys_clk);
      if (k >= 2) begin
        chk("out_valid", out_valid, 16'h1);
        chk("bridge_corrected", bridge_corrected, rows[k-2].eb);
        chk("temp_corrected", temp_corrected, rows[k-2].et);
        chk("target_prohibited", target_prohibited, rows[k-2].ep);
      end
      in_valid = (k < rows.size());
      if (k < rows.size()) begin
        coef = rows[k].c;
        bridge_raw_reading = rows[k].rb;
        temp_raw_reading = rows[k].rt;
      end
    end
    @(negedge sys_clk);
    chk("out_valid", out_valid, 16'h0);
    chk("bridge_corrected", bridge_corrected, rows[rows.size()-1].eb);
    $display("test stream done");
    // Mid-run reset with a sample in flight, then a sample at the first edge after release
    in_valid = 1'b1;
    coef = rows[1].c;
    bridge_raw_reading = rows[1].rb;
    @(negedge sys_clk);
    sys_rst = 1'b1;
    repeat (3) begin
      @(negedge sys_clk);
      chk("out_valid", out_valid, 16'h0);
      chk("bridge_corrected", bridge_corrected, 16'h0);
    end
    sys_rst = 1'b0;
    coef = rows[0].c;
    bridge_raw_reading = rows[0].rb;
    temp_raw_reading = rows[0].rt;
    @(negedge sys_clk);
    in_valid = 1'b0;
    @(negedge sys_clk);
    chk("out_valid", out_valid, 16'h1);
    chk("bridge_corrected", bridge_corrected, rows[0].eb);
    chk("temp_corrected", temp_corrected, rows[0].et);
    @(negedge sys_clk);
    chk("out_valid", out_valid, 16'h0);
    $display("test reset done");
    end_sim();
  end
endmodule // tb_top
